// [rtl/exc_prio_pkg.sv]
`default_nettype none
package exc_prio_pkg;
	// ----------------------------------------
	// priority ranks
	// ----------------------------------------
	localparam int NUM_RANKS = 15;
	typedef enum logic [3:0] {
		RANK_WARM_RESET = 4'h0,
		RANK_DBG_PREV = 4'h1,
		RANK_DBG_NEXT = 4'h2,
		RANK_FLUSH = 4'h3,
		RANK_SYS_MGMT = 4'h4,
		RANK_NMI = 4'h5,
		RANK_MASKABLE = 4'h6,
		RANK_FETCH_FAULT = 4'h7,
		RANK_DECODE_FAULT = 4'h8,
		RANK_WAIT_DNA = 4'h9,
		RANK_ESCAPE_DNA = 4'hA,
		RANK_FPU_ERR = 4'hB,
		RANK_SEG_FAULT = 4'hC,
		RANK_PAGE_FAULT = 4'hD,
		RANK_ALIGN = 4'hE,
		RANK_NONE = 4'hF
	} rank_t;

	// ----------------------------------------
	// exception kinds for error code
	// ----------------------------------------
	typedef enum logic [2:0] {
		KIND_DOUBLE = 3'h0,
		KIND_ALIGN = 3'h1,
		KIND_PAGE = 3'h2,
		KIND_TASK_SEG = 3'h3,
		KIND_NOT_PRESENT = 3'h4,
		KIND_STACK = 3'h5,
		KIND_GP = 3'h6,
		KIND_OTHER = 3'h7
	} fault_kind_t;

	// ----------------------------------------
	// error code fields
	// ----------------------------------------
	localparam int ERR_INDEX_LSB = 3;
	localparam int ERR_CAUSE_BIT = 2;
	localparam int ERR_ACCESS_BIT = 1;
	localparam int ERR_ORIGIN_BIT = 0;
	localparam logic [15:0] ERRCODE_RESET = 16'h0000;

	// ----------------------------------------
	// real-mode vectors
	// ----------------------------------------
	localparam logic [7:0] VEC_TABLE_OVERRUN = 8'h08;
	localparam logic [7:0] VEC_STACK_OVERRUN = 8'h0C;
	localparam logic [7:0] VEC_SEG_OVERRUN = 8'h0D;
	localparam logic [7:0] VEC_NONE = 8'h00;
endpackage
`default_nettype wire

// [rtl/exception_priority_errcode.sv]
`default_nettype none
// Functional notes
// - warm reset outranks every other event
// - previous-instruction debug, then next-instruction breakpoints
// - cache flush after debug, before interrupts
// - system-management interrupt just below flush
// - non-maskable beats maskable at same boundary
// - maskable request competes only with enable set
// - fetch faults below interrupts, then decode faults
// - wait with task-switched and monitor raises rank nine
// - escape with emulate or task-switched raises rank ten
// - float error only with numeric error enable
// - segmentation faults rank below float errors
// - page faults next, alignment check lowest
// - one exception per execution attempt
// - faults restartable except straddling task segment switch
// - real mode never raises task segment, not-present, page
// - real mode vectors eight, twelve, thirteen are overruns
// - protected-mode listed exceptions push 16-bit code
// - double fault and alignment code all zero
// - page code: protection, write, user bits
module exception_priority_errcode (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic boundary_i,
	input wire logic protected_mode_i,
	input wire logic warm_reset_request_i,
	input wire logic dbg_prev_i,
	input wire logic dbg_next_i,
	input wire logic flush_n_i,
	input wire logic sys_mgmt_interrupt_n_i,
	input wire logic nmi_i,
	input wire logic maskable_irq_i,
	input wire logic irq_enable_flag_i,
	input wire logic fetch_fault_i,
	input wire logic [2:0] fetch_fault_kind_i,
	input wire logic decode_fault_i,
	input wire logic wait_instr_i,
	input wire logic float_escape_instr_i,
	input wire logic task_switched_flag_i,
	input wire logic monitor_coproc_flag_i,
	input wire logic emulate_coproc_flag_i,
	input wire logic numeric_error_enable_i,
	input wire logic fpu_unmasked_exc_i,
	input wire logic seg_fault_i,
	input wire logic [2:0] seg_fault_kind_i,
	input wire logic page_fault_i,
	input wire logic align_fault_i,
	input wire logic task_state_segment_straddle_i,
	input wire logic [12:0] sel_index_i,
	input wire logic table_indicator_i,
	input wire logic table_fault_i,
	input wire logic handler_invoke_i,
	input wire logic errcode_cause_bit_i,
	input wire logic errcode_access_bit_i,
	input wire logic errcode_origin_bit_i,
	output logic take_o,
	output logic [3:0] rank_o,
	output logic [7:0] real_vector_o,
	output logic errcode_push_o,
	output logic [15:0] errcode_o,
	output logic restartable_o
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// async pins from the chipset; two flops before any logic
	localparam int NSYNC = 5;
	typedef struct packed {
		logic [1:0] rst_sync;
		logic [NSYNC-1:0] pin_s1;
		logic [NSYNC-1:0] pin_s2;
		logic take;
		logic [3:0] rank;
		logic [7:0] vec;
		logic push;
		logic [15:0] code;
		logic restart;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic rst_n;
	assign rst_n = st_r.rst_sync[1];

	logic [NSYNC-1:0] pins;
	assign pins = {warm_reset_request_i, ~flush_n_i, ~sys_mgmt_interrupt_n_i, nmi_i, maskable_irq_i};
	logic warm_s, flush_s, sysmgmt_s, nmi_s, maskable_s;
	assign {warm_s, flush_s, sysmgmt_s, nmi_s, maskable_s} = st_r.pin_s2;

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	logic [exc_prio_pkg::NUM_RANKS-1:0] req;
	logic seg_kind_real_ok;
	logic fetch_kind_real_ok;
	always_comb begin
		// real mode suppresses task segment, not-present and page faults from either source
		seg_kind_real_ok = protected_mode_i
			|| !(seg_fault_kind_i inside {exc_prio_pkg::KIND_PAGE, exc_prio_pkg::KIND_TASK_SEG,
				exc_prio_pkg::KIND_NOT_PRESENT});
		fetch_kind_real_ok = protected_mode_i
			|| !(fetch_fault_kind_i inside {exc_prio_pkg::KIND_PAGE, exc_prio_pkg::KIND_TASK_SEG,
				exc_prio_pkg::KIND_NOT_PRESENT});
		req = '0;
		req[exc_prio_pkg::RANK_WARM_RESET] = warm_s;
		req[exc_prio_pkg::RANK_DBG_PREV] = dbg_prev_i;
		req[exc_prio_pkg::RANK_DBG_NEXT] = dbg_next_i;
		req[exc_prio_pkg::RANK_FLUSH] = flush_s;
		req[exc_prio_pkg::RANK_SYS_MGMT] = sysmgmt_s;
		req[exc_prio_pkg::RANK_NMI] = nmi_s;
		req[exc_prio_pkg::RANK_MASKABLE] = maskable_s && irq_enable_flag_i;
		req[exc_prio_pkg::RANK_FETCH_FAULT] = fetch_fault_i && fetch_kind_real_ok;
		req[exc_prio_pkg::RANK_DECODE_FAULT] = decode_fault_i;
		req[exc_prio_pkg::RANK_WAIT_DNA] = wait_instr_i && task_switched_flag_i && monitor_coproc_flag_i;
		req[exc_prio_pkg::RANK_ESCAPE_DNA] = float_escape_instr_i
			&& (emulate_coproc_flag_i || task_switched_flag_i);
		req[exc_prio_pkg::RANK_FPU_ERR] = fpu_unmasked_exc_i && numeric_error_enable_i;
		req[exc_prio_pkg::RANK_SEG_FAULT] = seg_fault_i && seg_kind_real_ok;
		req[exc_prio_pkg::RANK_PAGE_FAULT] = page_fault_i && protected_mode_i;
		req[exc_prio_pkg::RANK_ALIGN] = align_fault_i;
	end

	// lowest index wins; one winner only, the rest stay at their sources
	logic [3:0] win;
	always_comb begin
		win = exc_prio_pkg::RANK_NONE;
		for (int i = exc_prio_pkg::NUM_RANKS - 1; i >= 0; i--) begin
			if (req[i]) begin
				win = 4'(i);
			end
		end
	end

	// ----------------------------------------
	// error code and vector
	// ----------------------------------------
	logic [2:0] kind;
	logic [15:0] code;
	logic push;
	logic [7:0] vec;
	always_comb begin
		kind = exc_prio_pkg::KIND_OTHER;
		if (win == exc_prio_pkg::RANK_FETCH_FAULT) begin
			kind = fetch_fault_kind_i;
		end else if (win == exc_prio_pkg::RANK_SEG_FAULT) begin
			kind = seg_fault_kind_i;
		end else if (win == exc_prio_pkg::RANK_PAGE_FAULT) begin
			kind = exc_prio_pkg::KIND_PAGE;
		end else if (win == exc_prio_pkg::RANK_ALIGN) begin
			kind = exc_prio_pkg::KIND_ALIGN;
		end
		push = protected_mode_i && (kind != exc_prio_pkg::KIND_OTHER);
		code = exc_prio_pkg::ERRCODE_RESET;
		if (kind == exc_prio_pkg::KIND_PAGE) begin
			code[exc_prio_pkg::ERR_CAUSE_BIT] = errcode_cause_bit_i;
			code[exc_prio_pkg::ERR_ACCESS_BIT] = errcode_access_bit_i;
			code[exc_prio_pkg::ERR_ORIGIN_BIT] = errcode_origin_bit_i;
		end else if (kind inside {exc_prio_pkg::KIND_TASK_SEG, exc_prio_pkg::KIND_NOT_PRESENT,
				exc_prio_pkg::KIND_STACK, exc_prio_pkg::KIND_GP}) begin
			code[15:exc_prio_pkg::ERR_INDEX_LSB] = sel_index_i;
			code[exc_prio_pkg::ERR_ORIGIN_BIT] = handler_invoke_i;
			if (table_fault_i) begin
				code[exc_prio_pkg::ERR_ACCESS_BIT] = 1'b1;
			end else begin
				code[exc_prio_pkg::ERR_CAUSE_BIT] = table_indicator_i;
			end
		end
		if (!push) begin
			code = exc_prio_pkg::ERRCODE_RESET;
		end
		// real mode overruns reuse vectors 8, 12, 13
		vec = exc_prio_pkg::VEC_NONE;
		if (!protected_mode_i && win == exc_prio_pkg::RANK_SEG_FAULT) begin
			if (seg_fault_kind_i == exc_prio_pkg::KIND_STACK) begin
				vec = exc_prio_pkg::VEC_STACK_OVERRUN;
			end else if (seg_fault_kind_i == exc_prio_pkg::KIND_DOUBLE) begin
				vec = exc_prio_pkg::VEC_TABLE_OVERRUN;
			end else begin
				vec = exc_prio_pkg::VEC_SEG_OVERRUN;
			end
		end
	end

	// ----------------------------------------
	// state update
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
		st_nxt.pin_s1 = pins;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.take = 1'b0;
		if (boundary_i && win != exc_prio_pkg::RANK_NONE) begin
			st_nxt.take = 1'b1;
			st_nxt.rank = win;
			st_nxt.vec = vec;
			st_nxt.push = push;
			st_nxt.code = code;
			// straddling task segment switch cannot be undone
			st_nxt.restart = !task_state_segment_straddle_i;
		end
		if (!rst_n) begin
			st_nxt.take = 1'b0;
			st_nxt.rank = exc_prio_pkg::RANK_NONE;
			st_nxt.vec = exc_prio_pkg::VEC_NONE;
			st_nxt.push = 1'b0;
			st_nxt.code = exc_prio_pkg::ERRCODE_RESET;
			st_nxt.restart = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= '0;
			st_r.rank <= exc_prio_pkg::RANK_NONE;
			st_r.restart <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign take_o = st_r.take;
	assign rank_o = st_r.rank;
	assign real_vector_o = st_r.vec;
	assign errcode_push_o = st_r.push;
	assign errcode_o = st_r.code;
	assign restartable_o = st_r.restart;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	a_warm_wins: assert property (boundary_i && warm_s |=> take_o && rank_o == 4'h0)
		else $error("warm reset not top rank");
	a_debug_order: assert property (boundary_i && !warm_s && dbg_prev_i |=> rank_o == 4'h1)
		else $error("previous debug not rank one");
	a_flush_rank: assert property (boundary_i && flush_s && req[2:0] == '0 |=> rank_o == 4'h3)
		else $error("flush rank wrong");
	a_sysmgmt_rank: assert property (boundary_i && sysmgmt_s && req[3:0] == '0 |=> rank_o == 4'h4)
		else $error("system-management rank wrong");
	a_nmi_first: assert property (boundary_i && nmi_s && req[4:0] == '0 |=> rank_o == 4'h5)
		else $error("nmi not before maskable");
	a_maskable_irq_masked: assert property (take_o |-> !(rank_o == 4'h6 && !$past(irq_enable_flag_i)))
		else $error("masked request taken");
	a_fpu_gate: assert property (take_o && rank_o == 4'hB |-> $past(numeric_error_enable_i))
		else $error("float error without enable");
	a_real_nopage: assert property (take_o && !$past(protected_mode_i) |-> rank_o != 4'hD && !errcode_push_o)
		else $error("page fault or code in real mode");
	a_align_zero: assert property (take_o && rank_o == 4'hE |-> errcode_o == 16'h0000)
		else $error("alignment code nonzero");
	a_no_boundary: assert property (!boundary_i |=> !take_o)
		else $error("taken off boundary");

	c_warm: cover property (boundary_i && warm_s && nmi_s);
	c_nmi_maskable: cover property (boundary_i && nmi_s && maskable_s && irq_enable_flag_i);
	c_page: cover property (take_o && rank_o == 4'hD && errcode_push_o);
endmodule
`default_nettype wire

// [verif/irq_source_model.sv]
`default_nettype none
module irq_source_model (
	input wire logic mclk_i,
	input wire logic [4:0] want_i,
	output logic warm_reset_request_o,
	output logic flush_n_o,
	output logic sys_mgmt_interrupt_n_o,
	output logic nmi_o,
	output logic maskable_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// chipset levels, held until withdrawn
	// ----------------------------------------
	initial begin
		warm_reset_request_o = 1'b0;
		flush_n_o = 1'b1;
		sys_mgmt_interrupt_n_o = 1'b1;
		nmi_o = 1'b0;
		maskable_irq_o = 1'b0;
	end
	// changes just after the edge; never a pulse, a boundary must see it
	always @(posedge mclk_i) begin
		warm_reset_request_o <= want_i[0];
		flush_n_o <= !want_i[1];
		sys_mgmt_interrupt_n_o <= !want_i[2];
		nmi_o <= want_i[3];
		maskable_irq_o <= want_i[4];
	end
endmodule
`default_nettype wire

// [verif/tb_exception_priority_errcode.sv]
`default_nettype none
module tb_exception_priority_errcode;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// stimulus and counters
	// ----------------------------------------
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic bnd = 1'b0;
	logic [22:0] f = 23'h000000;
	logic [4:0] ext = 5'h00;
	logic [2:0] fk = 3'h0;
	logic [2:0] sk = 3'h0;
	logic [12:0] idx = 13'h0000;
	integer seed = 32'hf114b7a1;
	int mismatches = 0;
	int compares = 0;
	logic wr, fl_n, sm_n, nmi, irq, take_o, push_o, rst_o;
	logic [3:0] rank_o;
	logic [7:0] vec_o;
	logic [15:0] code_o;
	always #50 mclk_i = !mclk_i;
	irq_source_model src_u (.mclk_i(mclk_i), .want_i(ext), .warm_reset_request_o(wr), .flush_n_o(fl_n),
		.sys_mgmt_interrupt_n_o(sm_n), .nmi_o(nmi), .maskable_irq_o(irq));
	exception_priority_errcode dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .boundary_i(bnd),
		.protected_mode_i(f[0]), .warm_reset_request_i(wr), .dbg_prev_i(f[1]), .dbg_next_i(f[2]),
		.flush_n_i(fl_n), .sys_mgmt_interrupt_n_i(sm_n), .nmi_i(nmi), .maskable_irq_i(irq),
		.irq_enable_flag_i(f[3]), .fetch_fault_i(f[4]), .fetch_fault_kind_i(fk), .decode_fault_i(f[5]),
		.wait_instr_i(f[6]), .float_escape_instr_i(f[7]), .task_switched_flag_i(f[8]),
		.monitor_coproc_flag_i(f[9]), .emulate_coproc_flag_i(f[10]), .numeric_error_enable_i(f[11]),
		.fpu_unmasked_exc_i(f[12]), .seg_fault_i(f[13]), .seg_fault_kind_i(sk), .page_fault_i(f[14]),
		.align_fault_i(f[15]), .task_state_segment_straddle_i(f[16]), .sel_index_i(idx),
		.table_indicator_i(f[17]),
		.table_fault_i(f[18]), .handler_invoke_i(f[19]), .errcode_cause_bit_i(f[20]),
		.errcode_access_bit_i(f[21]), .errcode_origin_bit_i(f[22]), .take_o(take_o), .rank_o(rank_o),
		.real_vector_o(vec_o), .errcode_push_o(push_o), .errcode_o(code_o), .restartable_o(rst_o));
	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic logic [3:0] exp_rank();
		logic rm;
		rm = !f[0];
		if (ext[0]) return 4'h0;
		if (f[1]) return 4'h1;
		if (f[2]) return 4'h2;
		if (ext[1]) return 4'h3;
		if (ext[2]) return 4'h4;
		if (ext[3]) return 4'h5;
		if (ext[4] && f[3]) return 4'h6;
		if (f[4] && !(rm && (fk inside {3'h2, 3'h3, 3'h4}))) return 4'h7;
		if (f[5]) return 4'h8;
		if (f[6] && f[8] && f[9]) return 4'h9;
		if (f[7] && (f[10] || f[8])) return 4'hA;
		if (f[12] && f[11]) return 4'hB;
		if (f[13] && !(rm && (sk inside {3'h2, 3'h3, 3'h4}))) return 4'hC;
		if (f[14] && !rm) return 4'hD;
		if (f[15]) return 4'hE;
		return 4'hF;
	endfunction
	task automatic bad(input string m);
		mismatches++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// requests settle three cycles (two for the synchronisers), then one boundary
	task automatic trial();
		logic [3:0] r;
		logic [2:0] kd;
		logic [15:0] c, m;
		logic [7:0] v;
		repeat (3) begin
			@(negedge mclk_i);
			compares++;
			if (take_o !== 1'b0) bad("take without boundary");
		end
		bnd = 1'b1;
		@(negedge mclk_i);
		bnd = 1'b0;
		r = exp_rank();
		compares++;
		if (take_o !== (r != 4'hF)) bad("take");
		if (r != 4'hF) begin
			kd = (r == 4'h7) ? fk : (r == 4'hC) ? sk : (r == 4'hD) ? 3'h2 : (r == 4'hE) ? 3'h1 : 3'h7;
			m = 16'hFFFF;
			if (kd < 3'h2) c = 16'h0000;
			else if (kd == 3'h2) begin
				c = {13'h0000, f[20], f[21], f[22]};
				m = 16'h0007;
			end else if (f[18]) begin
				c = {idx, 1'b0, 1'b1, f[19]};
				m = 16'hFFFB;
			end else c = {idx, f[17], 1'b0, f[19]};
			v = (!f[0] && r == 4'hC) ? ((sk == 3'h0) ? 8'h08 : (sk == 3'h5) ? 8'h0C : 8'h0D) : 8'h00;
			compares += 3;
			if (rank_o !== r) bad("rank");
			if (push_o !== (f[0] && kd != 3'h7)) bad("push");
			if (vec_o !== v) bad("real vector");
			if (push_o === 1'b1 && (code_o & m) !== c) bad("error code");
			compares++;
			if (r >= 4'h7 && rst_o !== !f[16]) bad("restartable");
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge mclk_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		f = '1;
		ext = 5'h1F;
		trial();
		f = 23'h000009;
		ext = 5'h18;
		trial();
		f = 23'h000001;
		ext = 5'h10;
		trial();
		ext = 5'h00;
		for (int k = 0; k < 8; k++) begin
			f = 23'h002000;
			sk = k[2:0];
			trial();
		end
		// sparse flags so the low ranks get their turn too
		for (int i = 0; i < 400; i++) begin
			f = 23'($random(seed) & $random(seed) & $random(seed));
			f[0] = 1'($random(seed));
			f[3] = 1'($random(seed));
			ext = 5'($random(seed) & $random(seed) & $random(seed));
			fk = 3'($random(seed));
			sk = 3'($random(seed));
			idx = 13'($random(seed));
			trial();
		end
		end_sim();
	end
endmodule
`default_nettype wire
